// [serial_config_port.sv]
/*
 * Write-only three-wire serial configuration port. Receives 32-bit
 * frames (header, address, value) and loads eight registers.
 * Assumes the shift clock is far slower than i_clk so that each of
 * its edges is seen after synchronisation; the pins are asynchronous.
 * The write strobe leads the new o_regs value by one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_config_port
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Serial pins, asynchronous
   input wire logic i_serial_clk,
   input wire logic i_serial_select_n,
   input wire logic i_serial_in_line,
   // Mode strap pin, asynchronous
   input wire logic i_extended_control_select,
   // Register bank and decoded controls
   output serial_config_pkg::reg_bank_s o_regs,
   output serial_config_pkg::out_ctrl_s o_out_ctrl,
   output logic o_extended_active,
   output logic o_write_strobe
);
   import serial_config_pkg::*;

   logic [3:0] pins_sync; // Synchronised pins
   logic sclk_s; // Synced shift clock
   logic sel_n_s; // Synced select
   logic serial_in_line_s; // Synced data
   logic ece_s; // Synced mode select
   logic sclk_prev_r; // Previous shift clock level
   logic sclk_rise; // Rising edge of shift clock
   rx_state_e state_r; // Receiver state
   logic [4:0] bit_cnt_r; // Bits taken in this frame
   logic [30:0] shift_r; // First 31 bits of frame
   logic [31:0] frame; // Completed frame
   logic frame_done; // Last bit taken this cycle
   logic hdr_ok; // Header matches
   reg_bank_s regs_r; // Stored register values
   logic write_en; // Frame commits a write
   logic [3:0] frame_addr; // Address field of frame
   logic [15:0] frame_value; // Value field of frame
   logic addr_mapped; // Address names a register

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers; select idles high
   pin_sync #(
      .WIDTH(4),
      .RST_VAL(4'h4)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_async({i_serial_clk, i_serial_select_n, i_serial_in_line,
         i_extended_control_select}),
      .o_sync(pins_sync)
   );
   assign sclk_s = pins_sync[3];
   assign sel_n_s = pins_sync[2];
   assign serial_in_line_s = pins_sync[1];
   assign ece_s = pins_sync[0];

   ////////////////////////////////////////////////////////////////////
   // Shift clock edge detector, on synchronised level only
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         // Shift clock idles low: no false edge after reset
         sclk_prev_r <= 1'b0;
      end
      else
      begin
         // Level one cycle back
         sclk_prev_r <= sclk_s;
      end
   end
   // Rising edge with select low
   assign sclk_rise = sclk_s & ~sclk_prev_r & ~sel_n_s;

   ////////////////////////////////////////////////////////////////////
   // Frame receiver: select low arms, edges count bits
   // No timeout on a partial frame; only select high or normal mode aborts
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         // Power-on: wait for the first edge
         state_r <= ST_IDLE;
         bit_cnt_r <= 5'h00;
      end
      else if (!ece_s || sel_n_s)
      begin
         // Normal mode or deselected: discard partial frame
         state_r <= ST_IDLE;
         bit_cnt_r <= 5'h00;
      end
      else
      begin
         // Extended mode and selected: count edges
         unique case (state_r)
            // Select low: ready for first bit
            ST_IDLE:
            begin
               if (sclk_rise)
               begin
                  state_r <= ST_SHIFT;
                  bit_cnt_r <= 5'h01;
               end
            end
            // Counting 32 bits; return to ST_IDLE lets the 33rd edge start anew
            ST_SHIFT:
            begin
               if (sclk_rise)
               begin
                  bit_cnt_r <= bit_cnt_r + 5'h01; // 31 wraps to 0
                  if (bit_cnt_r == LAST_BIT_IDX)
                  begin
                     // 32nd edge: frame complete, back to idle
                     state_r <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // MSB-first shift register
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         shift_r <= '0;
      end
      else if (sclk_rise && ece_s)
      begin
         // Runs across frames; only the last 31 bits are used
         shift_r <= {shift_r[29:0], serial_in_line_s};
      end
   end

   // Frame completes on the 32nd edge
   assign frame_done = ece_s && sclk_rise && (state_r == ST_SHIFT) &&
      (bit_cnt_r == LAST_BIT_IDX);
   assign frame = {shift_r, serial_in_line_s};
   assign hdr_ok = (frame[HDR_MSB:HDR_LSB] == HDR_PATTERN);
   assign write_en = frame_done && hdr_ok;
   assign frame_addr = frame[ADDR_MSB:ADDR_LSB];
   assign frame_value = frame[DATA_BITS-1:0];

   ////////////////////////////////////////////////////////////////////
   // Mapped-address decode; reserved codes commit nothing
   always_comb
   begin
      addr_mapped = 1'b0;
      unique case (frame_addr)
         // The eight register addresses
         ADDR_CONFIG, ADDR_I_OFFSET, ADDR_I_FULL_SCALE, ADDR_Q_OFFSET,
            ADDR_Q_FULL_SCALE, ADDR_DE_ENABLE, ADDR_DE_COARSE,
            ADDR_DE_FINE:
         begin
            addr_mapped = 1'b1;
         end
         // Reserved: 0, 4 to 9 and C
         default:
         begin
            addr_mapped = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Register bank; power-on values, write-only
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         regs_r.configuration <= RST_CONFIG;
         regs_r.i_channel_offset <= RST_I_OFFSET;
         regs_r.i_channel_full_scale <= RST_I_FULL_SCALE;
         regs_r.q_channel_offset <= RST_Q_OFFSET;
         regs_r.q_channel_full_scale <= RST_Q_FULL_SCALE;
         regs_r.dual_edge_enable <= RST_DE_ENABLE;
         regs_r.dual_edge_coarse_adjust <= RST_DE_COARSE;
         regs_r.dual_edge_fine_adjust <= RST_DE_FINE;
      end
      else if (write_en)
      begin
         // Address MSB first, value in low 16 bits
         unique case (frame_addr)
            ADDR_CONFIG: regs_r.configuration <= frame_value;
            ADDR_I_OFFSET: regs_r.i_channel_offset <= frame_value;
            ADDR_I_FULL_SCALE: regs_r.i_channel_full_scale <= frame_value;
            ADDR_Q_OFFSET: regs_r.q_channel_offset <= frame_value;
            ADDR_Q_FULL_SCALE: regs_r.q_channel_full_scale <= frame_value;
            ADDR_DE_ENABLE: regs_r.dual_edge_enable <= frame_value;
            ADDR_DE_COARSE: regs_r.dual_edge_coarse_adjust <= frame_value;
            ADDR_DE_FINE: regs_r.dual_edge_fine_adjust <= frame_value;
            // Reserved addresses leave the bank untouched
            default:
            begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs: in normal mode the core sees power-on values
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_regs <= {RST_CONFIG, RST_I_OFFSET, RST_I_FULL_SCALE,
            RST_Q_OFFSET, RST_Q_FULL_SCALE, RST_DE_ENABLE,
            RST_DE_COARSE, RST_DE_FINE};
         o_extended_active <= 1'b0;
      end
      else
      begin
         o_extended_active <= ece_s;
         if (ece_s)
         begin
            o_regs <= regs_r;
         end
         else
         begin
            // Normal mode: power-on values, stored contents kept
            o_regs <= {RST_CONFIG, RST_I_OFFSET, RST_I_FULL_SCALE,
               RST_Q_OFFSET, RST_Q_FULL_SCALE, RST_DE_ENABLE,
               RST_DE_COARSE, RST_DE_FINE};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Decoded output-clocking controls from the visible config
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_out_ctrl.duty_stabilizer_on <= RST_CONFIG[CFG_DUTY_STAB];
         o_out_ctrl.ddr_clock_phase <= RST_CONFIG[CFG_DDR_PHASE];
         o_out_ctrl.single_rate_select <= RST_CONFIG[CFG_SINGLE_RATE];
         o_out_ctrl.output_swing_select <= RST_CONFIG[CFG_SWING];
         o_out_ctrl.output_edge_rising <= 1'b0;
         o_out_ctrl.ddr_mode <= ~RST_CONFIG[CFG_SINGLE_RATE];
      end
      else
      begin
         // Follows the visible configuration one cycle later
         o_out_ctrl.duty_stabilizer_on <= o_regs.configuration[CFG_DUTY_STAB];
         o_out_ctrl.ddr_clock_phase <= o_regs.configuration[CFG_DDR_PHASE];
         o_out_ctrl.single_rate_select <=
            o_regs.configuration[CFG_SINGLE_RATE];
         o_out_ctrl.output_swing_select <= o_regs.configuration[CFG_SWING];
         // Edge choice only meaningful in single rate
         o_out_ctrl.output_edge_rising <=
            o_regs.configuration[CFG_SINGLE_RATE] &
            o_regs.configuration[CFG_OUT_EDGE];
         o_out_ctrl.ddr_mode <= ~o_regs.configuration[CFG_SINGLE_RATE];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // One-cycle pulse per committed write
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_write_strobe <= 1'b0;
      end
      else
      begin
         // Only frames that land in a register pulse it
         o_write_strobe <= write_en && addr_mapped;
      end
   end

endmodule // serial_config_port
`default_nettype wire

// [serial_config_pkg.sv]
/*
 * Constants and carrier types for the three-wire serial
 * configuration write port.
 * Assumes a 10 MHz system clock that oversamples the serial pins.
 */
`default_nettype none
package serial_config_pkg;

   // Frame layout, MSB first
   localparam int FRAME_BITS = 32;
   localparam int HDR_BITS = 12;
   localparam int ADDR_BITS = 4;
   localparam int DATA_BITS = 16;
   localparam int HDR_MSB = 31;
   localparam int HDR_LSB = 20;
   localparam int ADDR_MSB = 19;
   localparam int ADDR_LSB = 16;
   localparam logic [11:0] HDR_PATTERN = 12'h001;
   localparam logic [4:0] LAST_BIT_IDX = 5'h1F;

   // Register addresses
   localparam logic [3:0] ADDR_CONFIG = 4'h1;
   localparam logic [3:0] ADDR_I_OFFSET = 4'h2;
   localparam logic [3:0] ADDR_I_FULL_SCALE = 4'h3;
   localparam logic [3:0] ADDR_Q_OFFSET = 4'hA;
   localparam logic [3:0] ADDR_Q_FULL_SCALE = 4'hB;
   localparam logic [3:0] ADDR_DE_ENABLE = 4'hD;
   localparam logic [3:0] ADDR_DE_COARSE = 4'hE;
   localparam logic [3:0] ADDR_DE_FINE = 4'hF;

   // Power-on values
   localparam logic [15:0] RST_CONFIG = 16'hB2FF;
   localparam logic [15:0] RST_I_OFFSET = 16'h007F;
   localparam logic [15:0] RST_I_FULL_SCALE = 16'h807F;
   localparam logic [15:0] RST_Q_OFFSET = 16'h007F;
   localparam logic [15:0] RST_Q_FULL_SCALE = 16'h807F;
   localparam logic [15:0] RST_DE_ENABLE = 16'h3FFF;
   localparam logic [15:0] RST_DE_COARSE = 16'h0000;
   localparam logic [15:0] RST_DE_FINE = 16'h0000;

   // Configuration field positions
   localparam int CFG_DUTY_STAB = 12;
   localparam int CFG_DDR_PHASE = 11;
   localparam int CFG_SINGLE_RATE = 10;
   localparam int CFG_SWING = 9;
   localparam int CFG_OUT_EDGE = 8;

   // Synchroniser depth
   localparam int SYNC_STAGES = 2;

   // Register bank as seen by the converter core
   typedef struct packed {
      logic [15:0] configuration;
      logic [15:0] i_channel_offset;
      logic [15:0] i_channel_full_scale;
      logic [15:0] q_channel_offset;
      logic [15:0] q_channel_full_scale;
      logic [15:0] dual_edge_enable;
      logic [15:0] dual_edge_coarse_adjust;
      logic [15:0] dual_edge_fine_adjust;
   } reg_bank_s;

   // Decoded output-clocking controls
   typedef struct packed {
      logic duty_stabilizer_on;
      logic ddr_clock_phase;
      logic single_rate_select;
      logic output_swing_select;
      logic output_edge_rising;
      logic ddr_mode;
   } out_ctrl_s;

   // Frame receiver states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_SHIFT = 2'b10
   } rx_state_e;

endpackage
`default_nettype wire

// [pin_sync.sv]
/*
 * Two-flop synchroniser for a group of asynchronous pins.
 * Assumes the pins are quasi-static relative to the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Pins in, synchronised out
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_r; // First stage, read only by second

   ////////////////////////////////////////////////////////////////////
   // Two stages
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         meta_r <= RST_VAL;
         o_sync <= RST_VAL;
      end
      else
      begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule // pin_sync
`default_nettype wire

// [serial_host_model.sv]
/*
 * Host model that drives the three-wire write bus.
 * Assumes its tasks are called just after a rising edge of i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
(
   // System clock used for pacing
   input wire logic i_clk,
   // Serial pins towards the port
   output logic o_serial_clk,
   output logic o_serial_select_n,
   output logic o_serial_in_line
);
   // Idle bus: clock low, not selected
   initial
   begin
      o_serial_clk = 1'b0;
      o_serial_select_n = 1'b1;
      o_serial_in_line = 1'b0;
   end
   // Wait a number of rising edges
   task automatic ticks(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // Select drive; a released data line shows the inverse level
   task automatic set_sel(input logic v);
      o_serial_select_n <= v;
      if (v)
         o_serial_in_line <= ~o_serial_in_line;
      ticks(2);
   endtask
   // Shift nb leading bits of f, MSB first, h cycles per half period
   task automatic shift(input logic [31:0] f, input int nb, input int h);
      for (int i = 31; i > 31 - nb; i--)
      begin
         o_serial_in_line <= f[i];
         o_serial_clk <= 1'b0;
         ticks(h);
         o_serial_clk <= 1'b1;
         ticks(h);
      end
      // Clock stands still low between frames; one low phase ends it
      o_serial_clk <= 1'b0;
      ticks(h);
   endtask
endmodule // serial_host_model
`default_nettype wire

// [serial_config_port_checker.sv]
/*
 * Assertions on the serial configuration port.
 * Assumes it is bound to every instance of the port.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_config_port_checker
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_serial_clk,
   input wire logic i_serial_select_n,
   input wire logic i_serial_in_line,
   input wire logic i_extended_control_select,
   input wire serial_config_pkg::reg_bank_s o_regs,
   input wire serial_config_pkg::out_ctrl_s o_out_ctrl,
   input wire logic o_extended_active,
   input wire logic o_write_strobe
);
   import serial_config_pkg::*;
   // Power-on bank
   localparam reg_bank_s POR = {RST_CONFIG, RST_I_OFFSET, RST_I_FULL_SCALE,
      RST_Q_OFFSET, RST_Q_FULL_SCALE, RST_DE_ENABLE, RST_DE_COARSE,
      RST_DE_FINE};
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   a_ddr_decode: assert property (
      o_out_ctrl.ddr_mode == !$past(o_regs.configuration[CFG_SINGLE_RATE]))
      else $error("ddr mode not decoded");
   a_edge_decode: assert property (
      o_out_ctrl.output_edge_rising == $past(o_regs.configuration[10]
      & o_regs.configuration[8])) else $error("output edge not decoded");
   a_strobe_pulse: assert property (
      o_write_strobe |=> !o_write_strobe) else $error("strobe too long");
   a_regs_hold: assert property (
      o_extended_active && $past(o_extended_active)
      && $past(o_extended_active, 2) && !$past(o_write_strobe)
      |-> $stable(o_regs))
      else $error("registers changed without write");
   a_normal_por: assert property (
      !o_extended_active && !$past(o_extended_active) |-> o_regs == POR)
      else $error("normal mode not showing power-on values");
   a_select_quiet: assert property (
      i_serial_select_n [*8] |=> !o_write_strobe)
      else $error("write while not selected");
   a_mode_quiet: assert property (
      !i_extended_control_select [*8] |=> !o_write_strobe)
      else $error("write in normal mode");
   a_strobe_cause: assert property (
      o_write_strobe |-> $past(i_serial_clk, 2) && $past(i_serial_clk, 3)
      && !$past(i_serial_select_n, 3)) else $error("strobe without edge");
   a_mode_follow: assert property (
      $rose(i_extended_control_select) |-> ##[1:5] o_extended_active)
      else $error("mode pin not followed");
endmodule // serial_config_port_checker
bind serial_config_port serial_config_port_checker chk_u (
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_serial_clk(i_serial_clk),
   .i_serial_select_n(i_serial_select_n),
   .i_serial_in_line(i_serial_in_line),
   .i_extended_control_select(i_extended_control_select),
   .o_regs(o_regs), .o_out_ctrl(o_out_ctrl),
   .o_extended_active(o_extended_active), .o_write_strobe(o_write_strobe));
`default_nettype wire

// [test_serial_config_port.sv]
/*
 * Self-checking bench for the serial configuration port.
 * Assumes the host model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
`default_nettype none
module test_serial_config_port;
   import serial_config_pkg::*;
   logic i_clk, i_rst_b, mode;
   wire logic sclk, sel_n, sdat; // Host pins
   reg_bank_s regs, exp_bank;
   out_ctrl_s ctrl;
   logic ext_on, wr_strobe;
   int n_errors, n_tests, n_strobes, n_cycles;
   logic [3:0] addrs [8] = '{ADDR_DE_ENABLE, ADDR_I_OFFSET, ADDR_I_FULL_SCALE,
      ADDR_Q_OFFSET, ADDR_Q_FULL_SCALE, ADDR_DE_COARSE, ADDR_DE_FINE,
      ADDR_CONFIG};
   logic [15:0] vals [8] = '{16'h3FFF, 16'h1281, 16'h9E7F, 16'h5A7F,
      16'h707F, 16'h0003, 16'h00C0, 16'hB5FF};
   // Header plus address of refused frames
   logic [15:0] bad [10] = '{16'h0010, 16'h0014, 16'h0015, 16'h0016,
      16'h0017, 16'h0018, 16'h0019, 16'h001C, 16'h0021, 16'h8011};
   serial_config_port dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_serial_clk(sclk), .i_serial_select_n(sel_n),
      .i_serial_in_line(sdat), .i_extended_control_select(mode),
      .o_regs(regs), .o_out_ctrl(ctrl), .o_extended_active(ext_on),
      .o_write_strobe(wr_strobe));
   serial_host_model host_u (.i_clk(i_clk), .o_serial_clk(sclk),
      .o_serial_select_n(sel_n), .o_serial_in_line(sdat));
   ////////////////////////////////////////////////////////////////////
   // Clock
   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // Strobe count and hang guard
   always @(posedge i_clk)
   begin
      n_cycles++;
      if (wr_strobe === 1'b1)
         n_strobes++;
      if (n_cycles == 20000)
      begin
         n_errors++;
         close_out;
      end
   end
   // Compare seen against expected
   task automatic chk(input string what, input logic [127:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // Expected register bank after a write
   task automatic upd(input logic [3:0] a, input logic [15:0] d);
      case (a)
         ADDR_CONFIG: exp_bank.configuration = d;
         ADDR_I_OFFSET: exp_bank.i_channel_offset = d;
         ADDR_I_FULL_SCALE: exp_bank.i_channel_full_scale = d;
         ADDR_Q_OFFSET: exp_bank.q_channel_offset = d;
         ADDR_Q_FULL_SCALE: exp_bank.q_channel_full_scale = d;
         ADDR_DE_ENABLE: exp_bank.dual_edge_enable = d;
         ADDR_DE_COARSE: exp_bank.dual_edge_coarse_adjust = d;
         default: exp_bank.dual_edge_fine_adjust = d;
      endcase
   endtask
   // Verdict and end of run
   task automatic close_out;
      $display("checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Test sequence
   initial
   begin
      i_rst_b = 1'b0;
      mode = 1'b1;
      n_errors = 0;
      n_tests = 0;
      n_strobes = 0;
      n_cycles = 0;
      exp_bank = {RST_CONFIG, RST_I_OFFSET, RST_I_FULL_SCALE, RST_Q_OFFSET,
         RST_Q_FULL_SCALE, RST_DE_ENABLE, RST_DE_COARSE, RST_DE_FINE};
      repeat (16) @(posedge i_clk);
      i_rst_b <= 1'b1;
      host_u.ticks(4);
      chk("bank", regs, exp_bank);
      chk("ctrl", ctrl, 6'b100101);
      $display("power-on test done");
      // Eight writes back to back, select never raised
      // Dual-edge enable first at default, configuration last
      // No calibration runs in this bench, so frames may go at once
      host_u.set_sel(1'b0);
      foreach (addrs[i])
      begin
         host_u.shift({HDR_PATTERN, addrs[i], vals[i]}, 32, 4);
         upd(addrs[i], vals[i]);
      end
      host_u.ticks(8);
      chk("bank", regs, exp_bank);
      chk("ctrl", ctrl, 6'b101010);
      chk("strobes", n_strobes, 8);
      $display("write test done");
      // Reserved addresses and broken headers
      foreach (bad[i])
         host_u.shift({bad[i], 16'h0F0F}, 32, 4);
      host_u.ticks(8);
      chk("bank", regs, exp_bank);
      chk("strobes", n_strobes, 8);
      $display("refusal test done");
      // Aborted partial frame, then a slow frame
      host_u.shift({HDR_PATTERN, ADDR_I_FULL_SCALE, 16'h1111}, 20, 4);
      host_u.set_sel(1'b1);
      host_u.ticks(8);
      host_u.set_sel(1'b0);
      host_u.shift({HDR_PATTERN, ADDR_Q_OFFSET, 16'hC3A5}, 32, 24);
      upd(ADDR_Q_OFFSET, 16'hC3A5);
      host_u.ticks(8);
      chk("bank", regs, exp_bank);
      chk("strobes", n_strobes, 9);
      $display("abort test done");
      // Normal mode: power-on values shown, frames ignored
      mode <= 1'b0;
      host_u.ticks(8);
      chk("extended", ext_on, 1'b0);
      chk("bank", regs, {RST_CONFIG, RST_I_OFFSET, RST_I_FULL_SCALE,
         RST_Q_OFFSET, RST_Q_FULL_SCALE, RST_DE_ENABLE, RST_DE_COARSE,
         RST_DE_FINE});
      host_u.shift({HDR_PATTERN, ADDR_I_OFFSET, 16'h0000}, 32, 4);
      host_u.set_sel(1'b1);
      mode <= 1'b1;
      host_u.ticks(8);
      chk("extended", ext_on, 1'b1);
      chk("bank", regs, exp_bank);
      chk("strobes", n_strobes, 9);
      $display("mode test done");
      close_out;
   end
endmodule // test_serial_config_port
`default_nettype wire
